// ---- hdl/pdld_top.sv ----
// Digital lock detect for two loops and holdover exit, with register port
`timescale 1ns/1ps
module pdld_top (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // Register port
   input wire logic [3:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic reg_re_i,
   output logic [15:0] reg_rdata_o,
   // Loop one divider outputs
   input wire logic loop1_reference_divider_output_i,
   input wire logic loop1_feedback_divider_output_i,
   // Loop two divider outputs
   input wire logic loop2_reference_divider_output_i,
   input wire logic loop2_feedback_divider_output_i,
   // Holdover entry request
   input wire logic holdover_enter_i,
   // Lock and mode outputs
   output logic loop1_digital_lock_indication_o,
   output logic loop2_digital_lock_indication_o,
   output logic holdover_o,
   output logic [1:0] input_buffer_type_o
);

   typedef struct packed {
      logic [1:0] primary_loop_window_size;
      logic [1:0] secondary_loop_window_size;
      logic exit_sel;
      logic osc_input_doubler_enable;
      logic [1:0] input_buffer_type;
      logic [1:0] lock_lost_clear_bit;
      logic [13:0] primary_loop_lock_count;
      logic [13:0] secondary_loop_lock_count;
      logic [13:0] holdover_exit_lock_count;
      logic [1:0] lock;
      logic [1:0] lock_lost_sticky_flag;
      logic hold;
      logic [15:0] rdata;
   } pdld_top_state_t;

   pdld_top_state_t q;
   pdld_top_state_t d;

   logic l1_lock;
   logic l2_lock;
   logic hx_lock;
   logic [3:0] pri_win;
   logic [3:0] sec_win;

   pdld_pd_if pd1 ();
   pdld_pd_if pd2 ();

   // Window codes to cycle limits
   assign pri_win = pdld_pkg::win_cycles(q.primary_loop_window_size);
   assign sec_win = pdld_pkg::win_cycles(q.secondary_loop_window_size);

   // Loop one comparator
   pdld_edge_cmp u_cmp1 (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .reference_divider_output_i(loop1_reference_divider_output_i),
      .feedback_divider_output_i(loop1_feedback_divider_output_i),
      .both_edges_i(1'b0),
      .win_cycles_i(pri_win),
      .pd(pd1.src)
   );

   // Loop two comparator, reference doubled on request
   pdld_edge_cmp u_cmp2 (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .reference_divider_output_i(loop2_reference_divider_output_i),
      .feedback_divider_output_i(loop2_feedback_divider_output_i),
      .both_edges_i(q.osc_input_doubler_enable),
      .win_cycles_i(sec_win),
      .pd(pd2.src)
   );

   // Loop one lock event
   pdld_lock_cnt u_lock1 (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .pd(pd1.snk),
      .lock_count_i(q.primary_loop_lock_count),
      .lock_o(l1_lock)
   );

   // Loop two lock event
   pdld_lock_cnt u_lock2 (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .pd(pd2.snk),
      .lock_count_i(q.secondary_loop_lock_count),
      .lock_o(l2_lock)
   );

   // Holdover exit event on loop one's window
   pdld_lock_cnt u_lock_hx (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .pd(pd1.snk),
      .lock_count_i(q.holdover_exit_lock_count),
      .lock_o(hx_lock)
   );

   // Register access, lock flags and holdover
   always_comb
   begin
      logic [1:0] fall;
      fall = 2'h0;
      d = q;
      d.rdata = 16'h0000;
      if (reg_we_i)
      begin
         case (reg_addr_i)
            pdld_pkg::REG_CFG:
            begin
               d.primary_loop_window_size =
                  reg_wdata_i[pdld_pkg::CFG_PRI_WND_LSB +: 2];
               d.secondary_loop_window_size =
                  reg_wdata_i[pdld_pkg::CFG_SEC_WND_LSB +: 2];
               d.exit_sel = reg_wdata_i[pdld_pkg::CFG_EXIT_SEL_BIT];
               d.osc_input_doubler_enable = reg_wdata_i[pdld_pkg::CFG_DBL_EN_BIT];
               d.input_buffer_type = reg_wdata_i[pdld_pkg::CFG_BUF_TYPE_LSB +: 2];
               d.lock_lost_clear_bit[0] = reg_wdata_i[pdld_pkg::CFG_CLR1_BIT];
               d.lock_lost_clear_bit[1] = reg_wdata_i[pdld_pkg::CFG_CLR2_BIT];
            end
            pdld_pkg::REG_PRI_CNT:
            begin
               d.primary_loop_lock_count = reg_wdata_i[13:0];
            end
            pdld_pkg::REG_SEC_CNT:
            begin
               d.secondary_loop_lock_count = reg_wdata_i[13:0];
            end
            pdld_pkg::REG_HX_CNT:
            begin
               d.holdover_exit_lock_count = reg_wdata_i[13:0];
            end
            default:
            begin
               d.rdata = 16'h0000;
            end
         endcase
      end
      if (reg_re_i)
      begin
         case (reg_addr_i)
            pdld_pkg::REG_CFG:
            begin
               d.rdata[pdld_pkg::CFG_PRI_WND_LSB +: 2] = q.primary_loop_window_size;
               d.rdata[pdld_pkg::CFG_SEC_WND_LSB +: 2] = q.secondary_loop_window_size;
               d.rdata[pdld_pkg::CFG_EXIT_SEL_BIT] = q.exit_sel;
               d.rdata[pdld_pkg::CFG_DBL_EN_BIT] = q.osc_input_doubler_enable;
               d.rdata[pdld_pkg::CFG_BUF_TYPE_LSB +: 2] = q.input_buffer_type;
               d.rdata[pdld_pkg::CFG_CLR1_BIT] = q.lock_lost_clear_bit[0];
               d.rdata[pdld_pkg::CFG_CLR2_BIT] = q.lock_lost_clear_bit[1];
            end
            pdld_pkg::REG_PRI_CNT:
            begin
               d.rdata = {2'h0, q.primary_loop_lock_count};
            end
            pdld_pkg::REG_SEC_CNT:
            begin
               d.rdata = {2'h0, q.secondary_loop_lock_count};
            end
            pdld_pkg::REG_HX_CNT:
            begin
               d.rdata = {2'h0, q.holdover_exit_lock_count};
            end
            pdld_pkg::REG_STATUS:
            begin
               d.rdata[pdld_pkg::ST_LOCK1_BIT] = q.lock[0];
               d.rdata[pdld_pkg::ST_LOST1_BIT] = q.lock_lost_sticky_flag[0];
               d.rdata[pdld_pkg::ST_LOCK2_BIT] = q.lock[1];
               d.rdata[pdld_pkg::ST_LOST2_BIT] = q.lock_lost_sticky_flag[1];
               d.rdata[pdld_pkg::ST_HOLD_BIT] = q.hold;
               d.rdata[pdld_pkg::ST_HX_LOCK_BIT] = hx_lock;
            end
            default:
            begin
               d.rdata = 16'h0000; // Unmapped reads as zero
            end
         endcase
      end
      // Lock indications and sticky loss flags
      d.lock = {l2_lock, l1_lock};
      fall = q.lock & ~d.lock;
      d.lock_lost_sticky_flag = ~q.lock_lost_clear_bit &
         (q.lock_lost_sticky_flag | fall);
      // Holdover entry wins over a same-cycle exit
      if (holdover_enter_i)
      begin
         d.hold = 1'b1;
      end
      else if (q.hold && hx_lock && q.exit_sel)
      begin
         d.hold = 1'b0;
      end
   end

   // State register
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         q <= '0;
         q.primary_loop_window_size <= pdld_pkg::RST_PRI_WND;
         q.secondary_loop_window_size <= pdld_pkg::RST_SEC_WND;
         q.primary_loop_lock_count <= pdld_pkg::RST_PRI_CNT;
         q.secondary_loop_lock_count <= pdld_pkg::RST_SEC_CNT;
         q.holdover_exit_lock_count <= pdld_pkg::RST_HX_CNT;
      end
      else
      begin
         q <= d;
      end
   end

   // Outputs straight from state
   assign reg_rdata_o = q.rdata;
   assign loop1_digital_lock_indication_o = q.lock[0];
   assign loop2_digital_lock_indication_o = q.lock[1];
   assign holdover_o = q.hold;
   assign input_buffer_type_o = q.input_buffer_type;

   a_lock_follows_event: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      ##1 (q.lock == $past({l2_lock, l1_lock})))
      else $error("lock output does not follow lock event");
   a_lost_on_fall: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      ($fell(q.lock[0]) && !q.lock_lost_clear_bit[0] && !$past(q.lock_lost_clear_bit[0]))
      |=> q.lock_lost_sticky_flag[0])
      else $error("loop one lost flag not set on falling lock");
   a_lost_held_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      q.lock_lost_clear_bit[1] |=> !q.lock_lost_sticky_flag[1])
      else $error("loop two lost flag not held clear");
   a_lost_sticky: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (q.lock_lost_sticky_flag[1] && !q.lock_lost_clear_bit[1])
      |=> q.lock_lost_sticky_flag[1])
      else $error("loop two lost flag dropped without clear");
   a_hold_exit: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (q.hold && hx_lock && q.exit_sel && !holdover_enter_i) |=> !q.hold)
      else $error("holdover not left on exit event");
   a_hold_stays: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (q.hold && !q.exit_sel) |=> q.hold)
      else $error("holdover left while exit selection is zero");
   a_status_read: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (reg_re_i && reg_addr_i == pdld_pkg::REG_STATUS)
      |=> (q.rdata[pdld_pkg::ST_LOCK2_BIT] == $past(q.lock[1])))
      else $error("status read shows wrong loop two lock");
   a_read_one_cycle: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      !reg_re_i |=> (q.rdata == 16'h0000))
      else $error("read data present without read strobe");

endmodule // pdld_top

// ---- pkg/pdld_pkg.sv ----
// Shared constants, register map and helpers of the digital lock detector
package pdld_pkg;

   // Clock and window timing
   localparam int CLK_PERIOD_PS = 100000;
   localparam int WND_CODE1_PS = 1000;
   localparam int WND_CODE2_PS = 1800;
   localparam int WND_CODE3_PS = 2600;

   // Widths
   localparam int LOCK_CNT_W = 14;
   localparam int WIN_W = 4;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;

   // Register offsets
   localparam logic [3:0] REG_CFG = 4'h0;
   localparam logic [3:0] REG_PRI_CNT = 4'h1;
   localparam logic [3:0] REG_SEC_CNT = 4'h2;
   localparam logic [3:0] REG_HX_CNT = 4'h3;
   localparam logic [3:0] REG_STATUS = 4'h4;

   // Configuration field positions
   localparam int CFG_PRI_WND_LSB = 0;
   localparam int CFG_SEC_WND_LSB = 2;
   localparam int CFG_EXIT_SEL_BIT = 4;
   localparam int CFG_DBL_EN_BIT = 5;
   localparam int CFG_BUF_TYPE_LSB = 6;
   localparam int CFG_CLR1_BIT = 8;
   localparam int CFG_CLR2_BIT = 9;

   // Status field positions
   localparam int ST_LOCK1_BIT = 0;
   localparam int ST_LOST1_BIT = 1;
   localparam int ST_LOCK2_BIT = 2;
   localparam int ST_LOST2_BIT = 3;
   localparam int ST_HOLD_BIT = 4;
   localparam int ST_HX_LOCK_BIT = 5;

   // Reset values
   localparam logic [1:0] RST_PRI_WND = 2'h2;
   localparam logic [1:0] RST_SEC_WND = 2'h2;
   localparam logic [13:0] RST_PRI_CNT = 14'h0400;
   localparam logic [13:0] RST_SEC_CNT = 14'h2000;
   localparam logic [13:0] RST_HX_CNT = 14'h0400;

   // Window code to allowed edge separation in clock cycles, at least one
   function automatic logic [3:0] win_cycles(input logic [1:0] code);
      int ps;
      int cyc;
      case (code)
         2'h2: ps = WND_CODE2_PS;
         2'h3: ps = WND_CODE3_PS;
         default: ps = WND_CODE1_PS;
      endcase
      cyc = ps / CLK_PERIOD_PS;
      if (cyc < 1)
      begin
         cyc = 1;
      end
      return cyc[3:0];
   endfunction

endpackage

// ---- pkg/pdld_pd_if.sv ----
// Per phase detector cycle result carried from comparator to lock counters
`timescale 1ns/1ps
interface pdld_pd_if;
   logic pd_strobe;
   logic in_window;
   modport src (output pd_strobe, output in_window);
   modport snk (input pd_strobe, input in_window);
endinterface

// ---- hdl/pdld_edge_cmp.sv ----
// Edge window comparator for one loop's divider outputs
`timescale 1ns/1ps
module pdld_edge_cmp (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // Divider outputs from the pins
   input wire logic reference_divider_output_i,
   input wire logic feedback_divider_output_i,
   // Configuration
   input wire logic both_edges_i,
   input wire logic [3:0] win_cycles_i,
   // Result per phase detector cycle
   pdld_pd_if.src pd
);

   typedef enum logic [1:0] {PEND_IDLE, PEND_REF, PEND_FB} pdld_pend_t;

   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
      logic [1:0] s3;
      logic [1:0] lvl;
      pdld_pend_t pend;
      logic [3:0] cnt;
      logic strobe;
      logic inwin;
   } pdld_cmp_state_t;

   pdld_cmp_state_t q;
   pdld_cmp_state_t d;

   // Filter, edge detect and separation measurement
   always_comb
   begin
      logic [1:0] agree;
      logic [1:0] rise;
      logic [1:0] chg;
      logic rr;
      logic fr;
      logic lag;
      logic lead;
      agree = ~(q.s2 ^ q.s3);
      rise = agree & q.s3 & ~q.lvl;
      chg = agree & (q.s3 ^ q.lvl);
      rr = both_edges_i ? chg[0] : rise[0];
      fr = rise[1];
      d = q;
      d.s1 = {feedback_divider_output_i, reference_divider_output_i};
      d.s2 = q.s1;
      d.s3 = q.s2;
      d.lvl = (agree & q.s3) | (~agree & q.lvl);
      d.strobe = 1'b0;
      d.inwin = 1'b0;
      lag = (q.pend == PEND_REF) ? fr : rr;
      lead = (q.pend == PEND_REF) ? rr : fr;
      case (q.pend)
         PEND_IDLE:
         begin
            d.cnt = 4'h0;
            if (rr && fr)
            begin
               d.strobe = 1'b1;
               d.inwin = 1'b1;
            end
            else if (rr)
            begin
               d.pend = PEND_REF;
            end
            else if (fr)
            begin
               d.pend = PEND_FB;
            end
         end
         PEND_REF, PEND_FB:
         begin
            if (lag)
            begin
               d.strobe = 1'b1;
               d.inwin = 1'b1;
               d.pend = PEND_IDLE;
            end
            else if (lead || (q.cnt == win_cycles_i - 4'h1))
            begin
               d.strobe = 1'b1; // Missed partner edge
               d.pend = lead ? q.pend : PEND_IDLE;
               d.cnt = 4'h0;
            end
            else
            begin
               d.cnt = q.cnt + 4'h1;
            end
         end
         default:
         begin
            d.pend = PEND_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign pd.pd_strobe = q.strobe;
   assign pd.in_window = q.inwin;

   a_pending_bounded: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (q.pend != PEND_IDLE) |-> ##[1:16] q.strobe)
      else $error("pending edge never resolved");
   a_inwin_needs_strobe: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      q.inwin |-> q.strobe)
      else $error("in-window flag without strobe");

endmodule // pdld_edge_cmp

// ---- hdl/pdld_lock_cnt.sv ----
// Consecutive in-window counter producing one lock event level
`timescale 1ns/1ps
module pdld_lock_cnt (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // Phase detector results
   pdld_pd_if.snk pd,
   // Programmed lock count
   input wire logic [13:0] lock_count_i,
   // Lock level
   output logic lock_o
);

   typedef struct packed {
      logic [13:0] cnt;
      logic lock;
   } pdld_cnt_state_t;

   pdld_cnt_state_t q;
   pdld_cnt_state_t d;
   logic [13:0] target;

   // Zero count is invalid, treated as one
   assign target = (lock_count_i == 14'h0000) ? 14'h0001 : lock_count_i;

   // Count, saturate and clear
   always_comb
   begin
      d = q;
      if (pd.pd_strobe)
      begin
         if (!pd.in_window)
         begin
            d.cnt = 14'h0000;
            d.lock = 1'b0;
         end
         else if (q.cnt >= target)
         begin
            d.lock = 1'b1;
         end
         else
         begin
            d.cnt = q.cnt + 14'h0001;
            d.lock = q.lock | (q.cnt + 14'h0001 >= target);
         end
      end
   end

   // State register
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign lock_o = q.lock;

   a_miss_clears: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (pd.pd_strobe && !pd.in_window) |=> (q.cnt == 14'h0000 && !q.lock))
      else $error("out-of-window cycle did not clear counter");
   a_lock_at_count: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      $rose(q.lock) |-> (q.cnt >= $past(target)))
      else $error("lock rose before lock count reached");
   a_lock_holds: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (q.lock && !(pd.pd_strobe && !pd.in_window)) |=> q.lock)
      else $error("lock dropped without out-of-window cycle");

endmodule // pdld_lock_cnt

// ---- dv/tb_top.sv ----
// Self-checking bench of the digital lock detector
`timescale 1ns/1ps
module tb_top;
   typedef struct {
      logic [15:0] d;
      logic [4:0] p;
      bit pc;
   } pdld_note_t;

   // Design ports
   logic core_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [3:0] reg_addr_i = 4'h0;
   logic [15:0] reg_wdata_i = 16'h0000;
   logic reg_we_i = 1'b0;
   logic reg_re_i = 1'b0;
   logic [15:0] reg_rdata_o;
   logic l1_ref = 1'b0;
   logic l1_fb = 1'b0;
   logic l2_ref = 1'b0;
   logic l2_fb = 1'b0;
   logic hold_i = 1'b0;
   logic lock1;
   logic lock2;
   logic hold;
   logic [1:0] buf_t;

   // Bench state
   logic [2:0] ph = 3'h0;
   logic [2:0] sk2 = 3'h0;
   logic mute1 = 1'b1;
   logic mute2 = 1'b1;
   logic fast2 = 1'b0;
   logic [15:0] cfg = 16'h000a;
   logic [15:0] rst_v [5] = '{16'h000a, 16'h0400, 16'h2000, 16'h0400, 16'h0000};
   logic [31:0] seed = 32'h00013286; // Starts at 78470
   logic [31:0] r;
   pdld_note_t exp_q [$];
   pdld_note_t n;
   bit re_seen = 1'b0;
   int cyc = 0;
   int err_total = 0;
   int tests_run = 0;

   pdld_top u_pdld_top (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i),
      .reg_we_i(reg_we_i),
      .reg_re_i(reg_re_i),
      .reg_rdata_o(reg_rdata_o),
      .loop1_reference_divider_output_i(l1_ref),
      .loop1_feedback_divider_output_i(l1_fb),
      .loop2_reference_divider_output_i(l2_ref),
      .loop2_feedback_divider_output_i(l2_fb),
      .holdover_enter_i(hold_i),
      .loop1_digital_lock_indication_o(lock1),
      .loop2_digital_lock_indication_o(lock2),
      .holdover_o(hold),
      .input_buffer_type_o(buf_t)
   );

   // Clock of 100 ns
   initial
   begin
      forever #50 core_clk_i = ~core_clk_i;
   end

   // Divider waveforms, period of eight cycles (four for loop two feedback with fast2); a muted feedback misses its edge
   always @(posedge core_clk_i)
   begin
      ph <= ph + 3'h1;
      l1_ref <= ph < 3'h4;
      l1_fb <= !mute1 && ph < 3'h4;
      l2_ref <= ph < 3'h4;
      l2_fb <= !mute2 && (fast2 ? !ph[1] : (ph - sk2) < 3'h4);
   end

   // Hang guard
   always @(posedge core_clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         err_total++;
         end_of_test();
      end
   end

   // Compares each read answer with the oldest note
   always @(negedge core_clk_i)
   begin
      if (re_seen)
      begin
         n = exp_q.pop_front();
         chk("read data", n.d, reg_rdata_o);
         if (n.pc)
            chk("pins", {11'h000, n.p}, {11'h000, buf_t, hold, lock2, lock1});
      end
      re_seen = reg_re_i;
   end

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(input string s, input logic [15:0] e, input logic [15:0] v);
      tests_run++;
      if (v !== e)
      begin
         $display("Error %s expected %h seen %h", s, e, v);
         err_total++;
      end
   endtask

   task automatic cy(input int k);
      repeat (k) @(posedge core_clk_i);
   endtask

   // Waits for the edge just before a divider rising edge
   task automatic al();
      do @(negedge core_clk_i); while (ph != 3'h7);
      @(posedge core_clk_i);
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk_i);
      reg_we_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge core_clk_i);
      reg_we_i <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [15:0] d, input bit pc);
      @(posedge core_clk_i);
      reg_re_i <= 1'b1;
      reg_addr_i <= a;
      exp_q.push_back(pdld_note_t'{d, {cfg[7:6], d[4], d[2], d[0]}, pc});
      @(posedge core_clk_i);
      reg_re_i <= 1'b0;
   endtask

   task automatic wcfg(input logic [15:0] v);
      cfg = v;
      wr(pdld_pkg::REG_CFG, v);
   endtask

   task automatic st(input logic [5:0] e);
      rd(pdld_pkg::REG_STATUS, {10'h000, e}, 1'b1);
   endtask

   task automatic done(input string s);
      cy(2);
      $display("Test %s finished", s);
   endtask

   task automatic end_of_test();
      $display("Checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      cy(2);
      rst_n_i <= 1'b1;
      // Reset values, unmapped places read zero
      for (int a = 0; a < 16; a++)
         rd(a[3:0], a < 5 ? rst_v[a] : 16'h0000, a == 4);
      // Random counts keep 14 bits
      for (int i = 1; i < 4; i++)
      begin
         r = xs();
         wr(i[3:0], r[15:0]);
         rd(i[3:0], {2'h0, r[13:0]}, 1'b0);
      end
      wr(pdld_pkg::REG_STATUS, 16'hffff);
      st(6'h00);
      wr(4'h9, r[15:0]);
      rd(4'h9, 16'h0000, 1'b0);
      r = xs();
      wcfg({8'h00, r[7:6], 6'h0a});
      rd(pdld_pkg::REG_CFG, cfg, 1'b1);
      wr(pdld_pkg::REG_PRI_CNT, 16'h0004);
      wr(pdld_pkg::REG_SEC_CNT, 16'h0004);
      wr(pdld_pkg::REG_HX_CNT, 16'h0006);
      done("registers");
      // Loop one locks after four pairs, holdover exit lock after six
      al();
      mute1 <= 1'b0;
      cy(22);
      st(6'h00);
      cy(40);
      st(6'h21);
      // Loss of lock, then a single miss restarts the count
      al();
      mute1 <= 1'b1;
      cy(24);
      st(6'h02);
      al();
      mute1 <= 1'b0;
      cy(24);
      mute1 <= 1'b1;
      cy(8);
      mute1 <= 1'b0;
      cy(12);
      st(6'h02);
      cy(40);
      st(6'h23);
      done("loop one");
      // Sticky lost flag held clear by the clear bit
      wcfg(cfg | 16'h0100);
      st(6'h21);
      al();
      mute1 <= 1'b1;
      cy(24);
      st(6'h00);
      wcfg(cfg & 16'hfeff);
      cy(4);
      st(6'h00);
      done("lost flag");
      // Holdover kept until exit selection is one
      @(posedge core_clk_i);
      hold_i <= 1'b1;
      @(posedge core_clk_i);
      hold_i <= 1'b0;
      st(6'h10);
      al();
      mute1 <= 1'b0;
      cy(70);
      st(6'h31);
      wcfg(cfg | 16'h0010);
      cy(4);
      st(6'h21);
      done("holdover");
      // Loop two with every window code, one cycle apart
      for (int c = 0; c < 4; c++)
      begin
         wcfg({cfg[15:4], c[1:0], cfg[1:0]});
         al();
         mute2 <= 1'b1;
         sk2 <= 3'h1;
         cy(16);
         al();
         mute2 <= 1'b0;
         cy(50);
         st(c == 0 ? 6'h25 : 6'h2d);
      end
      al();
      mute2 <= 1'b1;
      sk2 <= 3'h2;
      cy(16);
      al();
      mute2 <= 1'b0;
      cy(50);
      st(6'h29);
      done("windows");
      // Doubler counts both reference edges
      al();
      mute2 <= 1'b1;
      sk2 <= 3'h0;
      cy(16);
      al();
      mute2 <= 1'b0;
      cy(50);
      st(6'h2d);
      wcfg(cfg | 16'h0020);
      cy(50);
      st(6'h29);
      al();
      fast2 <= 1'b1;
      cy(50);
      st(6'h2d);
      done("doubler");
      cy(4);
      end_of_test();
   end
endmodule // tb_top
